// File: verilog/mdpwm_top.sv
// Multichannel dimming PWM: serial register file, CLK supervision and five PWM channels.
// Assumes all pins synchronous to i_clk; CLK runs at 25.6 to 102.4 kHz in service.
`timescale 1ns/1ps
module mdpwm_top
	import mdpwm_pkg::*;
#(
	parameter int SLOW_LIMIT = SLOW_LIMIT_CYC     // Cycles without a CLK edge before failure
)(
	input  wire logic         i_clk,
	input  wire logic         i_reset_n,
	input  wire logic         i_chip_select_n,
	input  wire logic         i_sclk,
	input  wire logic         i_si,
	input  wire logic         i_pwm_clk,
	input  wire logic         i_fail_mode,
	input  wire logic [3:0]   i_control_input,
	output logic              o_so,
	output logic              o_so_oe_n,
	output logic              o_clk_fail,
	output logic [4:0]        o_channel_state
);
	typedef enum logic [1:0] {CLK_OK, CLK_FAIL} mdpwm_clk_e;

	mdpwm_frame_if frame_bus ();

	logic [7:0]  duty_reg     [NUM_CH];
	logic [1:0]  phase_reg    [NUM_CH];
	logic [1:0]  presc_reg    [NUM_CH];
	logic [4:0]  chan_on_reg;
	logic [3:0]  pse_reg;
	logic [4:0]  gsel_reg;
	logic [7:0]  gduty_reg;
	logic [1:0]  inen_reg     [NUM_INT];
	logic [1:0]  presc_cnt_reg[NUM_CH];
	logic [7:0]  period_reg   [NUM_CH];
	logic [2:0]  skip_frame_reg[NUM_CH];
	logic [7:0]  act_duty_reg [NUM_CH];
	logic [4:0]  active_reg;
	logic        pwm_clk_reg;
	logic [WATCH_BITS-1:0] watch_cnt_reg;
	mdpwm_clk_e  clk_state_reg;

	logic [3:0]  addr;
	logic        resync;
	logic        base_tick;
	logic        clk_failed;
	logic [4:0]  chan_tick;
	logic [4:0]  period_start;
	logic [4:0]  gate;
	logic [7:0]  req_duty     [NUM_CH];
	logic [7:0]  eff_duty     [NUM_CH];
	logic [7:0]  position     [NUM_CH];

	// Saturating duty step
	function automatic logic [7:0] step_duty(input logic [7:0] duty, input logic [1:0] size,
			input logic up);
		logic [8:0] amount;
		logic [8:0] sum;
		amount = 9'h000;
		case (size)
			2'h1:    amount = 9'h004;
			2'h2:    amount = 9'h008;
			2'h3:    amount = 9'h010;
			default: amount = 9'h000;
		endcase
		if (up) begin
			sum = {1'b0, duty} + amount;
			step_duty = sum[8] ? DUTY_FULL : sum[7:0];
		end else begin
			sum = {1'b0, duty} - amount;
			step_duty = sum[8] ? DUTY_RESET : sum[7:0];
		end
	endfunction : step_duty

	// True when this skipping frame runs at F7 for a duty of F8 to FE
	function automatic logic skip_low(input logic [7:0] duty, input logic [2:0] slot);
		logic [3:0] rank;
		logic [3:0] needed;
		case (slot)
			3'h0:    rank = 4'h1;
			3'h4:    rank = 4'h2;
			3'h2:    rank = 4'h3;
			3'h6:    rank = 4'h4;
			3'h1:    rank = 4'h5;
			3'h5:    rank = 4'h6;
			3'h3:    rank = 4'h7;
			default: rank = 4'h8;
		endcase
		needed = 4'(DUTY_FULL - duty);
		skip_low = (rank <= needed);
	endfunction : skip_low

	// Divider terminal count for a prescale code
	function automatic logic [1:0] presc_last(input logic [1:0] code);
		case (code)
			2'h0:    presc_last = 2'h3;
			2'h1:    presc_last = 2'h1;
			default: presc_last = 2'h0;
		endcase
	endfunction : presc_last

	mdpwm_spi_rx u_spi_rx (
		.i_clk           (i_clk),
		.i_reset_n       (i_reset_n),
		.i_chip_select_n (i_chip_select_n),
		.i_sclk          (i_sclk),
		.i_si            (i_si),
		.o_so            (o_so),
		.o_so_oe_n       (o_so_oe_n),
		.frame           (frame_bus.rx)
	);

	// Status shifted out on the next frame
	assign frame_bus.status_word = {o_clk_fail, i_fail_mode, 9'h000, o_channel_state};

	assign addr   = frame_bus.frame_data[ADDR_MSB:ADDR_LSB];
	assign resync = frame_bus.frame_valid && addr == ADDR_INIT2
		&& frame_bus.frame_data[RESYNC_BIT];

	// Channel control registers; all writes land at chip select release
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int c = 0; c < NUM_CH; c++) begin
				duty_reg[c]  <= DUTY_RESET;
				phase_reg[c] <= 2'h0;
			end
		end else if (frame_bus.frame_valid) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (addr == ADDR_CH_FIRST + 4'(c)) begin
					duty_reg[c]  <= frame_bus.frame_data[7:0];
					phase_reg[c] <= frame_bus.frame_data[PHASE_HI_BIT:PHASE_LO_BIT];
				end else if (addr == ADDR_STEP && c < NUM_INT) begin
					duty_reg[c] <= step_duty(duty_reg[c],
						frame_bus.frame_data[2*c +: 2],
						frame_bus.frame_data[STEP_DIR_BIT]);
				end
			end
		end
	end

	// On bits are one store shared by the channel registers and register 8
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			chan_on_reg <= 5'h00;
			pse_reg     <= 4'h0;
		end else if (frame_bus.frame_valid) begin
			if (addr == ADDR_OUTCTL) begin
				chan_on_reg <= frame_bus.frame_data[4:0];
				pse_reg     <= frame_bus.frame_data[PSE_LSB +: NUM_INT];
			end
			for (int c = 0; c < NUM_CH; c++) begin
				if (addr == ADDR_CH_FIRST + 4'(c)) begin
					chan_on_reg[c] <= frame_bus.frame_data[CHAN_ON_BIT];
				end
			end
		end
	end

	// Global duty, global select, input modes and prescalers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			gsel_reg  <= 5'h00;
			gduty_reg <= DUTY_RESET;
			for (int c = 0; c < NUM_INT; c++) begin
				inen_reg[c] <= INEN_PLAIN;
			end
			for (int c = 0; c < NUM_CH; c++) begin
				presc_reg[c] <= PRESC_RESET;
			end
		end else if (frame_bus.frame_valid) begin
			if (addr == ADDR_GLOBAL && !frame_bus.frame_data[SUBSEL_BIT]) begin
				gsel_reg <= frame_bus.frame_data[4:0];
			end
			if (addr == ADDR_GLOBAL && frame_bus.frame_data[SUBSEL_BIT]) begin
				gduty_reg <= frame_bus.frame_data[7:0];
			end
			for (int c = 0; c < NUM_INT; c++) begin
				if (addr == ADDR_INEN) begin
					inen_reg[c] <= frame_bus.frame_data[2*c +: 2];
				end
				if (addr == ADDR_PRESC && !frame_bus.frame_data[SUBSEL_BIT]) begin
					presc_reg[c] <= frame_bus.frame_data[2*c +: 2];
				end
			end
			if (addr == ADDR_PRESC && frame_bus.frame_data[SUBSEL_BIT]) begin
				presc_reg[NUM_CH-1] <= frame_bus.frame_data[1:0];
			end
		end
	end

	// Time base edge; the pin is already synchronous so one stage suffices
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pwm_clk_reg <= 1'b0;
		end else begin
			pwm_clk_reg <= i_pwm_clk;
		end
	end

	assign base_tick = i_pwm_clk & ~pwm_clk_reg;

	// CLK supervision: too long between edges or too short a period both fail
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// No edge seen yet, so the first edge after reset is never judged too fast
			watch_cnt_reg <= WATCH_BITS'(FAST_LIMIT_CYC);
			clk_state_reg <= CLK_OK;
		end else begin
			if (base_tick) begin
				watch_cnt_reg <= '0;
			end else if (watch_cnt_reg != {WATCH_BITS{1'b1}}) begin
				watch_cnt_reg <= watch_cnt_reg + 1'b1;
			end
			case (clk_state_reg)
				CLK_OK: begin
					if ((base_tick && watch_cnt_reg < WATCH_BITS'(FAST_LIMIT_CYC))
						|| watch_cnt_reg >= WATCH_BITS'(SLOW_LIMIT)) begin
						clk_state_reg <= CLK_FAIL;
					end
				end
				CLK_FAIL: begin
					if (base_tick && watch_cnt_reg >= WATCH_BITS'(FAST_LIMIT_CYC)
						&& watch_cnt_reg < WATCH_BITS'(SLOW_LIMIT)) begin
						clk_state_reg <= CLK_OK;                                   // Recover on one good period
					end
				end
				default: clk_state_reg <= CLK_FAIL;
			endcase
		end
	end

	assign clk_failed = (clk_state_reg != CLK_OK);

	// Per-channel gating and duty source selection
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			logic [1:0] mode;
			logic       in_lvl;
			logic       use_glob;
			mode     = (c < NUM_INT) ? inen_reg[c % NUM_INT] : INEN_PLAIN;
			in_lvl   = (c < NUM_INT) ? i_control_input[c % NUM_INT] : 1'b0;
			use_glob = gsel_reg[c] ^ (mode == INEN_SWAP && in_lvl);
			gate[c]  = chan_on_reg[c] && !(mode == INEN_GATE && !in_lvl);
			req_duty[c] = use_glob ? gduty_reg : duty_reg[c];
			eff_duty[c] = act_duty_reg[c];
			if (c < NUM_INT && pse_reg[c % NUM_INT] && act_duty_reg[c] >= DUTY_SKIP_MIN
				&& act_duty_reg[c] <= DUTY_SKIP_MAX
				&& skip_low(act_duty_reg[c], skip_frame_reg[c])) begin
				eff_duty[c] = DUTY_SKIP_LO;
			end
			position[c] = period_reg[c] + {phase_reg[c], 6'h00};
			chan_tick[c] = base_tick && presc_cnt_reg[c] == presc_last(presc_reg[c]);
			period_start[c] = chan_tick[c] && period_reg[c] == DUTY_FULL;
		end
	end

	// Prescalers, period counters and skipping frame counters, per channel
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int c = 0; c < NUM_CH; c++) begin
				presc_cnt_reg[c]  <= 2'h0;
				period_reg[c]     <= 8'h00;
				skip_frame_reg[c] <= 3'h0;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (resync) begin
					presc_cnt_reg[c]  <= 2'h0;
					period_reg[c]     <= 8'h00;
					skip_frame_reg[c] <= 3'h0;
				end else if (base_tick) begin
					presc_cnt_reg[c] <= chan_tick[c] ? 2'h0 : presc_cnt_reg[c] + 2'h1;
					if (chan_tick[c]) begin
						period_reg[c] <= period_reg[c] + 8'h01;
					end
					if (period_start[c]) begin
						skip_frame_reg[c] <= skip_frame_reg[c] + 3'h1;
					end
				end
			end
		end
	end

	// Active duty: full duty and off act at once, lower duty waits for the period
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			active_reg <= 5'h00;
			for (int c = 0; c < NUM_CH; c++) begin
				act_duty_reg[c] <= DUTY_RESET;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (!gate[c]) begin
					active_reg[c] <= 1'b0;
				end else if (req_duty[c] == DUTY_FULL) begin
					active_reg[c]   <= 1'b1;
					act_duty_reg[c] <= DUTY_FULL;
				end else if (period_start[c] || resync) begin
					active_reg[c]   <= 1'b1;
					act_duty_reg[c] <= req_duty[c];
				end
			end
		end
	end

	// Output stage; Fail mode hands internal outputs to their control inputs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_channel_state <= 5'h00;
			o_clk_fail      <= 1'b0;
		end else begin
			o_clk_fail <= clk_failed;
			for (int c = 0; c < NUM_CH; c++) begin
				if (i_fail_mode) begin
					o_channel_state[c] <= (c < NUM_INT) ? i_control_input[c % NUM_INT] : 1'b0;
				end else if (clk_failed) begin
					o_channel_state[c] <= gate[c];
				end else begin
					o_channel_state[c] <= active_reg[c] && (eff_duty[c] == DUTY_FULL
						|| position[c] < eff_duty[c]);
				end
			end
		end
	end
endmodule : mdpwm_top

// File: verilog/mdpwm_pkg.sv
// Constants shared by the dimming PWM block: frame layout, register map, timing.
// Assumes a 100 MHz system clock and a 25.6 to 102.4 kHz CLK time base pin.
package mdpwm_pkg;
	localparam int NUM_CH          = 5;             // Four internal channels and the external one
	localparam int NUM_INT         = 4;             // Internal channels only
	localparam int FRAME_BITS      = 16;

	// Frame fields
	localparam int ADDR_MSB        = 15;
	localparam int ADDR_LSB        = 12;
	localparam int WDOG_BIT        = 11;            // frame_watchdog_bit, not acted on here
	localparam int PHASE_HI_BIT    = 10;
	localparam int PHASE_LO_BIT    = 9;
	localparam int CHAN_ON_BIT     = 8;
	localparam int SUBSEL_BIT      = 8;             // Selects sub-register in #9 and #12
	localparam int RESYNC_BIT      = 1;
	localparam int STEP_DIR_BIT    = 8;
	localparam int PSE_LSB         = 5;
	localparam int PHASE_SHIFT     = 6;             // Phase code times 64 counts

	// Register addresses
	localparam logic [3:0] ADDR_INIT2    = 4'h1;
	localparam logic [3:0] ADDR_CH_FIRST = 4'h2;
	localparam logic [3:0] ADDR_CH_LAST  = 4'h6;
	localparam logic [3:0] ADDR_OUTCTL   = 4'h8;
	localparam logic [3:0] ADDR_GLOBAL   = 4'h9;
	localparam logic [3:0] ADDR_INEN     = 4'hb;
	localparam logic [3:0] ADDR_PRESC    = 4'hc;
	localparam logic [3:0] ADDR_STEP     = 4'he;

	// Duty values
	localparam logic [7:0] DUTY_FULL     = 8'hff;
	localparam logic [7:0] DUTY_SKIP_LO  = 8'hf7;
	localparam logic [7:0] DUTY_SKIP_MIN = 8'hf8;
	localparam logic [7:0] DUTY_SKIP_MAX = 8'hfe;
	localparam logic [7:0] DUTY_RESET    = 8'h00;
	localparam logic [1:0] PRESC_RESET   = 2'h0;

	// Input enable modes
	localparam logic [1:0] INEN_PLAIN    = 2'h0;
	localparam logic [1:0] INEN_GATE     = 2'h1;
	localparam logic [1:0] INEN_SWAP     = 2'h3;

	// CLK supervision timing
	localparam int SYS_CLK_NS      = 10;
	localparam int CLK_PER_MIN_NS  = 9766;          // 102.4 kHz
	localparam int CLK_PER_MAX_NS  = 39063;         // 25.6 kHz
	localparam int FAST_LIMIT_CYC  = CLK_PER_MIN_NS / 2 / SYS_CLK_NS;
	localparam int SLOW_LIMIT_CYC  = (CLK_PER_MAX_NS * 2 + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int WATCH_BITS      = 17;
endpackage : mdpwm_pkg

// File: verilog/mdpwm_frame_if.sv
// Carrier between the serial frame receiver and the PWM core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface mdpwm_frame_if;
	logic        frame_valid;   // One-cycle pulse at chip select rising edge
	logic [15:0] frame_data;    // Last 16 bits shifted in
	logic [15:0] status_word;   // Loaded into the serial output at frame start

	modport rx (output frame_valid, output frame_data, input status_word);
	modport core (input frame_valid, input frame_data, output status_word);
endinterface : mdpwm_frame_if

// File: verilog/mdpwm_spi_rx.sv
// Serial frame receiver: shifts SI on SCLK falling, drives SO on SCLK rising.
// Assumes chip select, clock and data pins are synchronous to i_clk.
`timescale 1ns/1ps
module mdpwm_spi_rx
	import mdpwm_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_reset_n,
	input  wire logic  i_chip_select_n,
	input  wire logic  i_sclk,
	input  wire logic  i_si,
	output logic       o_so,
	output logic       o_so_oe_n,
	mdpwm_frame_if.rx  frame
);
	logic        cs_n_reg;
	logic        sclk_reg;
	logic [15:0] rx_shift_reg;
	logic [15:0] tx_shift_reg;
	logic        cs_fall;
	logic        cs_rise;
	logic        sclk_fall;
	logic        sclk_rise;

	// Pin history for edge finding
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cs_n_reg <= 1'b1;
			sclk_reg <= 1'b0;
		end else begin
			cs_n_reg <= i_chip_select_n;
			sclk_reg <= i_sclk;
		end
	end

	assign cs_fall   = cs_n_reg & ~i_chip_select_n;
	assign cs_rise   = ~cs_n_reg & i_chip_select_n;
	assign sclk_fall = sclk_reg & ~i_sclk & ~i_chip_select_n;
	assign sclk_rise = ~sclk_reg & i_sclk & ~i_chip_select_n;

	// Receive; last 16 bits win so a daisy chain still works
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_shift_reg <= 16'h0000;
		end else if (sclk_fall) begin
			rx_shift_reg <= {rx_shift_reg[14:0], i_si};
		end
	end

	// Frame strobe at chip select release
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			frame.frame_valid <= 1'b0;
			frame.frame_data  <= 16'h0000;
		end else begin
			frame.frame_valid <= cs_rise;
			if (cs_rise) begin
				frame.frame_data <= rx_shift_reg;
			end
		end
	end

	// Transmit status, MSB first; tri-stated outside a frame
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_shift_reg <= 16'h0000;
			o_so         <= 1'b0;
			o_so_oe_n    <= 1'b1;
		end else if (cs_fall) begin
			tx_shift_reg <= {frame.status_word[14:0], 1'b0};
			o_so         <= frame.status_word[15];
			o_so_oe_n    <= 1'b0;
		end else if (cs_rise) begin
			o_so_oe_n    <= 1'b1;
		end else if (sclk_rise) begin
			o_so         <= tx_shift_reg[15];
			tx_shift_reg <= {tx_shift_reg[14:0], i_si}; // Passes data on down the chain
		end
	end
endmodule : mdpwm_spi_rx

// File: test/mdpwm_checker.sv
// Port-level assertions for the dimming PWM top.
// Assumes pins synchronous to i_clk and CLK pin low at reset.
`timescale 1ns/1ps
module mdpwm_checker #(
	parameter int SLOW_LIMIT = 3000
)(
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic       i_chip_select_n,
	input wire logic       i_pwm_clk,
	input wire logic       i_fail_mode,
	input wire logic [3:0] i_control_input,
	input wire logic       o_clk_fail,
	input wire logic [4:0] o_channel_state
);
	logic        pclk_q;
	logic        seen;
	logic        rise;
	logic [19:0] since;
	logic [19:0] gap;

	assign rise = i_pwm_clk && !pclk_q;

	// Age of the last CLK rise and the last period; saturates so a stall never wraps
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pclk_q <= 1'b0;
			seen   <= 1'b0;
			since  <= 20'h0;
			gap    <= 20'h0;
		end else begin
			pclk_q <= i_pwm_clk;
			seen   <= seen | rise;
			since  <= rise ? 20'h0 : (&since ? since : since + 20'h1);
			if (rise)
				gap <= since;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_fail_ext_off;
		i_fail_mode [*6] |-> !o_channel_state[4];
	endproperty
	a_fail_ext_off: assert property (p_fail_ext_off) else $error("external on in fail mode");
	property p_fail_react;
		$rose(i_fail_mode) |-> ##[1:6] !o_channel_state[4];
	endproperty
	a_fail_react: assert property (p_fail_react) else $error("slow fail mode reaction");
	property p_fail_follow;
		(i_fail_mode && $stable(i_control_input)) [*6] |-> o_channel_state[3:0] == i_control_input;
	endproperty
	a_fail_follow: assert property (p_fail_follow) else $error("fail mode output mismatch");
	property p_clk_fail_hold;
		(o_clk_fail && !i_fail_mode && i_chip_select_n && $stable(i_control_input)) [*8]
			|-> $stable(o_channel_state);
	endproperty
	a_clk_fail_hold: assert property (p_clk_fail_hold) else $error("pwm during clk fail");
	property p_no_tick;
		(i_chip_select_n && !i_fail_mode && !o_clk_fail && $stable(i_pwm_clk)
			&& $stable(i_control_input)) [*8] |-> $stable(o_channel_state);
	endproperty
	a_no_tick: assert property (p_no_tick) else $error("output moved without a tick");
	property p_fast;
		rise && seen && since < 20'd480 |-> ##[1:8] o_clk_fail;
	endproperty
	a_fast: assert property (p_fast) else $error("fast clk not flagged");
	property p_slow;
		since >= 20'(SLOW_LIMIT + 8) |-> o_clk_fail;
	endproperty
	a_slow: assert property (p_slow) else $error("stalled clk not flagged");
	property p_recover;
		$fell(o_clk_fail) |-> since < 20'd8 && gap >= 20'd480;
	endproperty
	a_recover: assert property (p_recover) else $error("clk fail cleared without good edge");

	c_clk_fail: cover property ($rose(o_clk_fail));
	c_fail_mode: cover property (i_fail_mode && o_channel_state[1]);
	c_frame: cover property ($rose(i_chip_select_n));
endmodule : mdpwm_checker

bind mdpwm_top mdpwm_checker #(.SLOW_LIMIT(SLOW_LIMIT)) u_mdpwm_checker (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_chip_select_n(i_chip_select_n),
	.i_pwm_clk(i_pwm_clk),
	.i_fail_mode(i_fail_mode),
	.i_control_input(i_control_input),
	.o_clk_fail(o_clk_fail),
	.o_channel_state(o_channel_state)
);

// File: test/mdpwm_mcu_model.sv
// Host microcontroller model: SPI master writing 16-bit frames.
// Assumes the 100 MHz system clock; SCLK stays high for three cycles and low for six.
`timescale 1ns/1ps
module mdpwm_mcu_model (
	input  wire logic i_clk,
	output logic      o_chip_select_n,
	output logic      o_sclk,
	output logic      o_si
);
	// Idle bus: deselected, clock low
	initial begin
		o_chip_select_n = 1'b1;
		o_sclk = 1'b0;
		o_si = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
	endtask : wait_clk

	// MSB first; SI moves only while SCLK is low so the falling edge sees it settled
	task automatic send_frame(input logic [15:0] word);
		o_chip_select_n <= 1'b0;
		wait_clk(4);
		for (int i = 15; i >= 0; i--) begin
			o_si <= word[i];
			wait_clk(3);
			o_sclk <= 1'b1;
			wait_clk(3);
			o_sclk <= 1'b0;
			wait_clk(3);
		end
		o_si <= ~word[0];                  // Stale data is not left on the line
		o_chip_select_n <= 1'b1;
		wait_clk(8);                       // Covers the write and the output update
	endtask : send_frame
endmodule : mdpwm_mcu_model

// File: test/mdpwm_tb.sv
// Self-checking bench for the dimming PWM top with a host frame model.
// Assumes CLK periods of 500 system cycles and SLOW_LIMIT cut to 3000.
`timescale 1ns/1ps
module mdpwm_tb
	import mdpwm_pkg::*;
;
	localparam int SLOW = 3000;
	logic       clk;
	logic       reset_n;
	logic       pwm_clk;
	logic       fail_mode;
	logic [3:0] control_input;
	logic       cs_n;
	logic       sclk;
	logic       si;
	logic       clk_fail;
	logic [4:0] chan;
	logic       so;
	logic       so_oe_n;
	int         num_errors;
	int         checks_done;
	int         cycles;

	mdpwm_top #(.SLOW_LIMIT(SLOW)) u_mdpwm_top (
		.i_clk(clk),
		.i_reset_n(reset_n),
		.i_chip_select_n(cs_n),
		.i_sclk(sclk),
		.i_si(si),
		.i_pwm_clk(pwm_clk),
		.i_fail_mode(fail_mode),
		.i_control_input(control_input),
		.o_so(so),
		.o_so_oe_n(so_oe_n),
		.o_clk_fail(clk_fail),
		.o_channel_state(chan)
	);
	mdpwm_mcu_model u_mdpwm_mcu_model (
		.i_clk(clk),
		.o_chip_select_n(cs_n),
		.o_sclk(sclk),
		.o_si(si)
	);

	initial clk = 1'b0;
	always #5 clk = ~clk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// Hang guard well above the expected 26k cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			$display("[FAIL] %0t run hung", $time);
			report_and_stop();
		end
	end

	task automatic check_eq(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check_eq

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_clk
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		u_mdpwm_mcu_model.send_frame({a, d});
	endtask : wr
	task automatic chw(input int ch, input logic on, input logic [1:0] ph, input logic [7:0] duty);
		wr(4'(ADDR_CH_FIRST + 4'(ch)), {1'b0, ph, on, duty});
	endtask : chw
	task automatic resync();
		wr(ADDR_INIT2, 12'h002);
	endtask : resync
	// CLK pin pulses; half is in system cycles
	task automatic tick(input int n, input int half);
		repeat (n) begin
			pwm_clk <= 1'b1;
			wait_clk(half);
			pwm_clk <= 1'b0;
			wait_clk(half);
		end
	endtask : tick

	task automatic t_full();
		tick(1, 250);
		chw(1, 1'b1, 2'h0, 8'hff);
		check_eq(8'(chan[1]), 8'h01, "full duty on");
		chw(1, 1'b1, 2'h0, 8'h10);
		check_eq(8'(chan[1]), 8'h01, "sub-full waits");
		chw(1, 1'b0, 2'h0, 8'h10);
		check_eq(8'(chan[1]), 8'h00, "turn off");
		wr(ADDR_OUTCTL, 12'h014);
		check_eq(8'(chan), 8'h00, "mirror with duty 00");
		chw(2, 1'b0, 2'h0, 8'hff);
		wr(ADDR_OUTCTL, 12'h004);
		check_eq(8'(chan), 8'h04, "on via reg 8");
		chw(2, 1'b0, 2'h0, 8'hff);
		check_eq(8'(chan), 8'h00, "off via channel reg");
		$display("test full_and_mirror done");
	endtask : t_full

	// Duty 42 at phase 1 stays high only while the period count is below 2 or at C0 and above
	task automatic t_prescale();
		for (int code = 0; code < 4; code++) begin
			chw(0, 1'b0, 2'h1, 8'h42);
			wr(ADDR_PRESC, {10'h0, 2'(code)});
			chw(0, 1'b1, 2'h1, 8'h42);
			resync();
			check_eq(8'(chan[0]), 8'h01, "after resync");
			tick(2, 250);
			check_eq(8'(chan[0]), 8'(code < 2), "after 2 ticks");
			tick(2, 250);
			check_eq(8'(chan[0]), 8'(code == 0), "after 4 ticks");
		end
		chw(0, 1'b0, 2'h1, 8'h42);
		$display("test prescale done");
	endtask : t_prescale

	task automatic t_global();
		tick(1, 250);
		wr(ADDR_GLOBAL, 12'h141);
		wr(ADDR_GLOBAL, 12'h00c);
		chw(2, 1'b1, 2'h2, 8'h00);
		chw(3, 1'b1, 2'h1, 8'h00);
		resync();
		check_eq(8'(chan[3:2]), 8'h02, "global keeps phase");
		wr(ADDR_INEN, 12'h040);
		check_eq(8'(chan[3]), 8'h00, "gated low");
		control_input <= 4'h8;
		resync();
		check_eq(8'(chan[3]), 8'h01, "gated high");
		wr(ADDR_INEN, 12'h0c0);
		resync();
		check_eq(8'(chan[3]), 8'h00, "swap to own");
		control_input <= 4'h0;
		wait_clk(4);
		resync();
		check_eq(8'(chan[3]), 8'h01, "swap back global");
		wr(ADDR_INEN, 12'h000);
		wr(ADDR_GLOBAL, 12'h000);
		resync();
		check_eq(8'(chan[3:2]), 8'h00, "own duty again");
		$display("test global done");
	endtask : t_global

	task automatic t_step();
		tick(1, 250);
		wr(ADDR_PRESC, 12'h0ff);
		for (int i = 0; i < 5; i++)
			chw(i, 1'b1, 2'h1, 8'h3c);
		wr(ADDR_STEP, 12'h1e4);
		resync();
		check_eq(8'(chan), 8'h0c, "step sizes");
		tick(4, 250);
		check_eq(8'(chan), 8'h08, "step 8 vs 16");
		for (int i = 0; i < 4; i++)
			chw(i, 1'b1, 2'h0, 8'h05);
		wr(ADDR_STEP, 12'h0ff);
		resync();
		check_eq(8'(chan[3:0]), 8'h00, "floor at 00");
		for (int i = 0; i < 4; i++)
			chw(i, 1'b1, 2'h3, 8'hf8);
		wr(ADDR_STEP, 12'h1ff);
		resync();
		check_eq(8'(chan[3:0]), 8'h0f, "ceiling at ff");
		$display("test step done");
	endtask : t_step

	task automatic t_clk_fail();
		wr(ADDR_OUTCTL, 12'h000);
		chw(0, 1'b1, 2'h0, 8'h00);
		resync();
		check_eq(8'(chan), 8'h00, "duty 00 low");
		wait_clk(SLOW + 20);
		check_eq(8'({clk_fail, chan}), 8'h21, "stall forces full");
		fail_mode <= 1'b1;
		control_input <= 4'h2;
		wait_clk(10);
		check_eq(8'(chan), 8'h02, "fail mode inputs");
		fail_mode <= 1'b0;
		control_input <= 4'h0;
		tick(2, 250);
		check_eq(8'({clk_fail, chan}), 8'h00, "recovered");
		tick(2, 100);
		check_eq(8'(clk_fail), 8'h01, "fast clk");
		tick(2, 250);
		check_eq(8'(clk_fail), 8'h00, "fast recovered");
		$display("test clk_fail done");
	endtask : t_clk_fail

	initial begin
		reset_n = 1'b0;
		pwm_clk = 1'b0;
		fail_mode = 1'b0;
		control_input = 4'h0;
		num_errors = 0;
		checks_done = 0;
		cycles = 0;
		wait_clk(6);
		reset_n <= 1'b1;
		wait_clk(2);
		check_eq(8'({clk_fail, chan}), 8'h00, "reset state");
		check_eq(8'({so_oe_n, so}), 8'h02, "serial out idle");
		t_full();
		t_prescale();
		t_global();
		t_step();
		t_clk_fail();
		report_and_stop();
	end
endmodule : mdpwm_tb
